// ===== css_osc_model.sv
// Behavioural model of the oscillators and watchdog tick source that feed the start-up block.
`timescale 1ns/1ps
module css_osc_model #(
   parameter int HALF_NS = 160
) (
   // Oscillator ticks.
   output logic [3:0] src_ck_pin,
   output logic wdt_osc_pin
);
   // -------------------------------------------------------------------------
   // Free-running sources
   // -------------------------------------------------------------------------
   // All sources swing in phase with one fixed period, so the watchdog count and the
   // source count line up and a reset delay can be judged in source edges alone.
   initial begin
      src_ck_pin = 4'h0;
      wdt_osc_pin = 1'b0;
      forever begin
         #(HALF_NS);
         src_ck_pin = ~src_ck_pin;
         wdt_osc_pin = ~wdt_osc_pin;
      end
   end
endmodule // css_osc_model

// ===== css_pkg.sv
// Constants, codes and carrier types of the clock source select and start-up block.
package css_pkg;

   // -------------------------------------------------------------------------
   // Fuse codes of the source-select and start-up fields
   // -------------------------------------------------------------------------
   localparam logic [3:0] SRC_CODE_EXT = 4'h0;
   localparam logic [3:0] SRC_CODE_RC4 = 4'h2;
   localparam logic [3:0] SRC_CODE_RC8 = 4'h4;
   localparam logic [3:0] SRC_CODE_LF = 4'h6;
   localparam logic [1:0] STARTUP_RES = 2'h3;
   localparam logic [1:0] STARTUP_SHIP = 2'h2;
   // One-hot source positions: external pin, RC, 128 kHz, crystal.
   localparam int SRC_EXT = 0;
   localparam int SRC_RC = 1;
   localparam int SRC_LF = 2;
   localparam int SRC_XT = 3;
   // Crystal reset-delay class per {source_select_bit0, start-up code}: 0 none, 1 short, 2 long.
   localparam logic [15:0] XT_RST_MAP = 16'h9249;

   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int WAKE_CK_RC = 6;
   localparam int CK_258 = 258;
   localparam int CK_1K = 1024;
   localparam int CK_16K = 16384;
   localparam int RST_CK = 14;
   localparam int MS_SHORT = 4;
   localparam int MS_LONG = 64;
   localparam int WDT_KHZ = 128;
   localparam int TICKS_SHORT = MS_SHORT * WDT_KHZ;
   localparam int TICKS_LONG = MS_LONG * WDT_KHZ;
   localparam logic [14:0] SYNC_WAIT = 15'h0002;

   // -------------------------------------------------------------------------
   // Register map and fields
   // -------------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_CAL = 8'h08;
   localparam logic [7:0] ADDR_FUSE = 8'h0C;
   localparam int CTRL_SLEEP_BIT = 0;
   localparam int CTRL_DIV8_BIT = 1;
   localparam logic [7:0] CAL_RST = 8'h80;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef enum logic [5:0] {
      S_LOAD = 6'h01,
      S_RT = 6'h02,
      S_CK = 6'h04,
      S_RUN = 6'h08,
      S_SLEEP = 6'h10,
      S_ERR = 6'h20
   } css_state_e;

   typedef struct packed {
      logic [3:0] clock_source_select;
      logic [1:0] startup_time_select;
      logic div8_n;
      logic rstdis_n;
   } css_fuse_s;

   typedef struct packed {
      css_state_e st;
      css_fuse_s fuse;
      logic [14:0] cnt;
      logic [13:0] rt;
      logic [3:0] ck_prev;
      logic wdt_prev;
      logic wake_prev;
      logic clk_en;
      logic div8;
      logic [3:0] src_oh;
      logic rc_fast;
      logic [7:0] cal;
      logic err;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } css_state_s;

endpackage

// ===== css_startup.sv
// Clock source selection, start-up delay timing and clock release controller.
// Operation
// - Pick the source from a four-bit fuse field; odd codes below 1000 are reserved.
// - A fuse bit reads programmed at 0 and unprogrammed at 1.
// - Code 0000 takes the system clock from the external clock pin.
// - Code 0010 selects the RC oscillator at 4 MHz, 0100 at 8 MHz.
// - Code 0110 selects the 128 kHz low-power oscillator.
// - Codes 1000 to 1111 select the crystal or resonator oscillator.
// - On wake, count six source cycles for external and RC sources.
// - From reset add a real-time delay timed by the watchdog oscillator.
// - External source reset delay: 00 is 14 CK, 01 adds 4 ms, 10 adds 64 ms.
// - RC source uses the same delays; shipped start-up code is 10.
// - Default is 8 MHz RC, longest start-up, divide by eight: 1 MHz.
// - A programmed divide-by-eight fuse starts the clock divided by eight.
// - Each reset copies the factory calibration byte into the calibration register.
// - The watchdog oscillator keeps timing the reset time-out under any source.
// - Flash interface clock runs and stops together with the CPU clock.
// - With the reset pin disabled, a plain 14 CK reset delay becomes 14 CK plus 4 ms.
// - The 128 kHz source wakes in 6 CK with the same three reset delays.
// - Crystal wake delay is 258, 1K or 16K CK by bit 0 and start-up code.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module css_startup
   import css_pkg::*;
#(
   parameter int P_TICKS_LONG = TICKS_LONG,
   parameter int P_CK16K = CK_16K
) (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic ce,
   // Fuses, oscillator ticks and wake pin, all asynchronous.
   input wire css_fuse_s fuse_pin,
   input wire logic [3:0] src_ck_pin,
   input wire logic wdt_osc_pin,
   input wire logic wake_pin,
   // Factory calibration byte from the non-volatile reader.
   input wire logic [7:0] cal_factory,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock gating and oscillator control.
   output logic cpu_clk_en,
   output logic io_clk_en,
   output logic flash_clk_en,
   output logic [3:0] src_sel_oh,
   output logic rc_fast,
   output logic clk_div8,
   output logic [7:0] osc_trim,
   output logic cfg_error
);

   // -------------------------------------------------------------------------
   // Input synchronisation and edge detection
   // -------------------------------------------------------------------------
   css_state_s q;
   css_state_s n;
   css_fuse_s sy_fuse;
   logic [3:0] sy_ck;
   logic sy_wdt;
   logic sy_wake;
   logic ck_rise;
   logic wdt_rise;
   logic wake_rise;
   logic acc;
   logic wr;
   logic [31:0] rd_val;

   css_sync #(.W(14)) u_sync (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .ce(ce),
      .d({fuse_pin, src_ck_pin, wdt_osc_pin, wake_pin}),
      .q({sy_fuse, sy_ck, sy_wdt, sy_wake})
   );

   // Only the selected source may advance the cycle count.
   assign ck_rise = |(sy_ck & ~q.ck_prev & q.src_oh);
   assign wdt_rise = sy_wdt & ~q.wdt_prev;
   assign wake_rise = sy_wake & ~q.wake_prev;

   // -------------------------------------------------------------------------
   // Fuse decoding
   // -------------------------------------------------------------------------
   // Reserved source codes and the reserved start-up code stop the block.
   function automatic logic cfg_bad(css_fuse_s f);
      logic [3:0] c;
      c = f.clock_source_select;
      return !c[3] && (c[0] || f.startup_time_select == STARTUP_RES);
   endfunction

   // Code values are compared as printed: a 0 bit is a programmed fuse.
   function automatic logic [1:0] src_idx(css_fuse_s f);
      if (f.clock_source_select[3]) return 2'(SRC_XT);
      if (f.clock_source_select == SRC_CODE_EXT) return 2'(SRC_EXT);
      if (f.clock_source_select == SRC_CODE_LF) return 2'(SRC_LF);
      return 2'(SRC_RC);
   endfunction

   // Source cycles to wait on wake; the reset path adds RST_CK to it.
   function automatic logic [14:0] wake_ck(css_fuse_s f);
      logic [2:0] i;
      i = {f.clock_source_select[0], f.startup_time_select};
      if (f.clock_source_select[3]) begin
         if (!i[2] && !i[1]) return 15'(CK_258);
         if (i[2] && i[1:0] != 2'h0) return 15'(P_CK16K);
         return 15'(CK_1K);
      end
      return 15'(WAKE_CK_RC);
   endfunction

   // Watchdog ticks of the real-time reset delay.
   function automatic logic [13:0] rst_ticks(css_fuse_s f);
      logic [1:0] m;
      m = f.startup_time_select;
      if (f.clock_source_select[3]) begin
         m = XT_RST_MAP[{f.clock_source_select[0], f.startup_time_select, 1'b0} +: 2];
      end
      // A disabled reset pin needs time to enter programming mode.
      if (m == 2'h0 && !f.rstdis_n) m = 2'h1;
      unique case (m)
         2'h1: return 14'(TICKS_SHORT);
         2'h2: return 14'(P_TICKS_LONG);
         default: return 14'h0000;
      endcase
   endfunction

   // Register decode for the error answer; the read mux decodes the offsets in its own case.
   function automatic logic reg_hit(logic [7:0] a);
      return a == ADDR_CTRL || a == ADDR_STAT || a == ADDR_CAL || a == ADDR_FUSE;
   endfunction

   // -------------------------------------------------------------------------
   // APB access
   // -------------------------------------------------------------------------
   // One wait state: pready rises in the second access cycle.
   assign acc = psel & penable;
   assign wr = acc & pwrite & q.pready;

   // Read data, taken from state so reads never disturb the sequence.
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (paddr)
         ADDR_CTRL: rd_val[CTRL_DIV8_BIT] = q.div8;
         ADDR_STAT: rd_val = {15'h0000, q.err, q.rc_fast, q.clk_en, q.src_oh, 6'(q.st), 4'h0};
         ADDR_CAL: rd_val[7:0] = q.cal;
         ADDR_FUSE: rd_val[7:0] = q.fuse;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // -------------------------------------------------------------------------
   // Start-up sequencer
   // -------------------------------------------------------------------------
   always_comb begin
      n = q;
      n.ck_prev = sy_ck;
      n.wdt_prev = sy_wdt;
      n.wake_prev = sy_wake;
      n.pready = acc & ~q.pready;
      n.pslverr = acc & ~q.pready & ~reg_hit(paddr);
      if (acc & ~q.pready) n.prdata = rd_val;
      unique case (q.st)
         S_LOAD: begin
            // Fuses are sampled once the synchroniser has filled.
            n.cal = cal_factory;
            if (q.cnt != SYNC_WAIT) begin
               n.cnt = q.cnt + 15'h0001;
            end else begin
               n.fuse = sy_fuse;
               n.div8 = !sy_fuse.div8_n;
               n.src_oh = 4'h0;
               n.src_oh[src_idx(sy_fuse)] = 1'b1;
               n.rc_fast = sy_fuse.clock_source_select == SRC_CODE_RC8;
               if (cfg_bad(sy_fuse)) begin
                  n.err = 1'b1;
                  n.st = S_ERR;
               end else begin
                  n.rt = rst_ticks(sy_fuse);
                  n.cnt = wake_ck(sy_fuse) + 15'(RST_CK);
                  n.st = S_RT;
               end
            end
         end
         S_RT: begin
            // Real-time part runs on the watchdog oscillator only.
            if (q.rt == 14'h0000) n.st = S_CK;
            else if (wdt_rise) n.rt = q.rt - 14'h0001;
         end
         S_CK: begin
            if (ck_rise) begin
               if (q.cnt == 15'h0001) begin
                  // Enable flips on a core edge; the gate cell latches it.
                  n.clk_en = 1'b1;
                  n.st = S_RUN;
               end else begin
                  n.cnt = q.cnt - 15'h0001;
               end
            end
         end
         S_RUN: begin
            if (wr && paddr == ADDR_CTRL && pwdata[CTRL_SLEEP_BIT]) begin
               n.clk_en = 1'b0;
               n.st = S_SLEEP;
            end
         end
         S_SLEEP: begin
            if (wake_rise) begin
               n.cnt = wake_ck(q.fuse);
               n.st = S_CK;
            end
         end
         S_ERR: n.clk_en = 1'b0;
         default: n.st = S_ERR;
      endcase
      // Software may retune or change the divider after the load.
      if (wr && q.st != S_LOAD) begin
         if (paddr == ADDR_CAL) n.cal = pwdata[7:0];
         if (paddr == ADDR_CTRL) n.div8 = pwdata[CTRL_DIV8_BIT];
      end
   end

   // State register; the clock enable freezes everything.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.st <= S_LOAD;
         q.cal <= CAL_RST;
      end else if (ce) begin
         q <= n;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   // CPU, I/O and flash enables share one flop so they can never part.
   assign cpu_clk_en = q.clk_en;
   assign io_clk_en = q.clk_en;
   assign flash_clk_en = q.clk_en;
   assign src_sel_oh = q.src_oh;
   assign rc_fast = q.rc_fast;
   assign clk_div8 = q.div8;
   assign osc_trim = q.cal;
   assign cfg_error = q.err;
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   a_reserved_code_halts: assert property (
      ce && q.st == S_LOAD && q.cnt == SYNC_WAIT && cfg_bad(sy_fuse)
      |=> q.st == S_ERR && q.err && !q.clk_en ##1 !q.clk_en)
      else $error("reserved code did not halt");

   a_ext_pin_source: assert property (
      q.st == S_RUN && q.fuse.clock_source_select == SRC_CODE_EXT |-> q.src_oh == 4'b0001)
      else $error("external pin not selected");

   a_rc_source_speed: assert property (
      q.st == S_RUN && (q.fuse.clock_source_select == SRC_CODE_RC4
      || q.fuse.clock_source_select == SRC_CODE_RC8) |-> q.src_oh == 4'b0010
      && q.rc_fast == (q.fuse.clock_source_select == SRC_CODE_RC8))
      else $error("rc source or speed wrong");

   a_lf_source: assert property (
      q.st == S_RUN && q.fuse.clock_source_select == SRC_CODE_LF |-> q.src_oh == 4'b0100)
      else $error("low-power source not selected");

   a_xtal_source: assert property (
      q.st == S_RUN && q.fuse.clock_source_select[3] |-> q.src_oh == 4'b1000)
      else $error("crystal source not selected");

   a_div8_from_fuse: assert property (
      $past(q.st) == S_LOAD && q.st != S_LOAD |-> q.div8 == !q.fuse.div8_n)
      else $error("divide by eight not taken from fuse");

   a_cal_copied: assert property (
      $past(q.st) == S_LOAD && q.st != S_LOAD |-> q.cal == $past(cal_factory))
      else $error("calibration byte not loaded");

   a_rt_needs_tick: assert property (
      ce && q.st == S_RT && q.rt != 14'h0000 && !wdt_rise |=> q.rt == $past(q.rt))
      else $error("real-time count moved without watchdog tick");

   // Non-crystal load values, decoded here apart from the design's functions.
   a_rt_load_value: assert property (
      $past(q.st) == S_LOAD && q.st == S_RT && !q.fuse.clock_source_select[3]
      && q.fuse.rstdis_n |-> q.cnt == 15'(WAKE_CK_RC + RST_CK)
      && q.rt == (q.fuse.startup_time_select == 2'h2 ? 14'(P_TICKS_LONG)
      : q.fuse.startup_time_select == 2'h1 ? 14'(TICKS_SHORT) : 14'h0000))
      else $error("reset delay loaded wrong");

   a_default_longest: assert property (
      q.st == S_RT && $past(q.st) == S_LOAD && q.fuse.clock_source_select == SRC_CODE_RC8
      && q.fuse.startup_time_select == STARTUP_SHIP |-> q.rt == 14'(P_TICKS_LONG))
      else $error("default setting lacks longest delay");

   a_release_on_count: assert property (
      $rose(q.clk_en) |-> $past(q.st) == S_CK && $past(q.cnt) == 15'h0001
      && $past(ck_rise))
      else $error("clocks released before count expired");

   a_gated_in_startup: assert property (
      q.st != S_RUN |-> !cpu_clk_en && !flash_clk_en && !io_clk_en)
      else $error("clock enabled outside run");

   a_wake_short_count: assert property (
      ce && q.st == S_SLEEP && wake_rise && !q.fuse.clock_source_select[3]
      |=> q.st == S_CK && q.cnt == 15'(WAKE_CK_RC))
      else $error("wake count not six source cycles");

   a_xtal_short_wake: assert property (
      $past(q.st) == S_LOAD && q.st == S_RT && q.fuse.clock_source_select[3]
      && !q.fuse.clock_source_select[0] && !q.fuse.startup_time_select[1]
      |-> q.cnt == 15'(CK_258 + RST_CK))
      else $error("crystal short wake count wrong");

   a_wdt_tick_counts: assert property (
      ce && q.st == S_RT && q.rt != 14'h0000 && wdt_rise |=> q.rt == $past(q.rt) - 14'h0001)
      else $error("watchdog tick not counted");

   // A sleep request must stop CPU, I/O and flash clocks on the same edge.
   a_sleep_gates_all: assert property (
      ce && q.st == S_RUN && wr && paddr == ADDR_CTRL && pwdata[CTRL_SLEEP_BIT]
      |=> !cpu_clk_en && !flash_clk_en && !io_clk_en)
      else $error("sleep left a clock running");

   a_rstdis_short: assert property (
      $past(q.st) == S_LOAD && q.st == S_RT && !q.fuse.rstdis_n |-> q.rt != 14'h0000)
      else $error("disabled reset pin got no real-time delay");

   a_err_stays_gated: assert property (
      q.st == S_ERR |=> q.st == S_ERR && !cpu_clk_en)
      else $error("error state left or clocks released");

endmodule // css_startup

// ===== css_sync.sv
// Two-flop synchroniser for inputs that arrive from outside the core clock domain.
`timescale 1ns/1ps
module css_sync #(
   parameter int W = 1
) (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic ce,
   // Data.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   // The first stage feeds only the second one.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= '0;
         q <= '0;
      end else if (ce) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // css_sync

// ===== testbench.sv
// Self-checking testbench of the clock source select and start-up block.
`timescale 1ns/1ps
module testbench;
   import css_pkg::*;
   // Shortened long counts keep the run brief.
   localparam int TL = 16;
   localparam int T16 = 32;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   css_fuse_s fuse_pin = 8'hFF;
   logic [3:0] src_ck_pin;
   logic wdt_osc_pin;
   logic wake_pin = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, cpu_clk_en, io_clk_en, flash_clk_en, rc_fast, clk_div8, cfg_error;
   logic [3:0] src_sel_oh;
   logic [7:0] osc_trim;
   logic [31:0] rd;
   logic se;
   logic prev_tick = 1'b0;
   int sel = 0;
   int edges = 0;
   int err_count = 0;
   int total_checks = 0;

   always #25 core_clk = ~core_clk;

   css_osc_model u_osc (.src_ck_pin(src_ck_pin), .wdt_osc_pin(wdt_osc_pin));

   css_startup #(.P_TICKS_LONG(TL), .P_CK16K(T16)) u_dut (
      .core_clk(core_clk), .arst_n(arst_n), .ce(1'b1), .fuse_pin(fuse_pin),
      .src_ck_pin(src_ck_pin), .wdt_osc_pin(wdt_osc_pin), .wake_pin(wake_pin),
      .cal_factory(8'hC3), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_clk_en(cpu_clk_en), .io_clk_en(io_clk_en),
      .flash_clk_en(flash_clk_en), .src_sel_oh(src_sel_oh), .rc_fast(rc_fast),
      .clk_div8(clk_div8), .osc_trim(osc_trim), .cfg_error(cfg_error));

   // Running count of rising edges of the selected source; tasks take differences.
   always @(posedge core_clk) begin
      prev_tick <= src_ck_pin[sel];
      if (src_ck_pin[sel] && !prev_tick) begin
         edges <= edges + 1;
      end
   end

   // -------------------------------------------------------------------------
   // Checking and closing
   // -------------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Counts are bench-made integers, so a plain range test is enough.
   task automatic chk_rng(input int got, input int lo, input int hi);
      total_checks++;
      if (got < lo || got > hi) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic conclude();
      if (err_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // -------------------------------------------------------------------------
   // Drivers
   // -------------------------------------------------------------------------
   // One APB transfer; the request is held until pready is seen at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         chk(32'h0, 32'h1);
         conclude();
      end
   endtask

   // Waits on a settled clock enable; a timeout ends the run.
   task automatic wait_en(input int lim);
      int n;
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= lim) begin
         chk(32'h0, 32'h1);
         conclude();
      end
   endtask

   // Source edges from reset release to clock release, from the fuse tables.
   function automatic int exp_edges(input css_fuse_s f);
      int w, t, i;
      i = {f.clock_source_select[0], f.startup_time_select};
      if (f.clock_source_select[3]) begin
         w = (i < 2) ? CK_258 : (i < 5) ? CK_1K : T16;
         t = (i % 3 == 0) ? TICKS_SHORT : (i % 3 == 1) ? TL : 0;
      end else begin
         w = WAKE_CK_RC;
         t = (f.startup_time_select == 2'h0) ? 0 : (f.startup_time_select == 2'h1) ? TICKS_SHORT : TL;
      end
      if (t == 0 && !f.rstdis_n) begin
         t = TICKS_SHORT;
      end
      return w + RST_CK + t;
   endfunction

   // Fuses change only while reset is held, well ahead of the release.
   task automatic rst(input css_fuse_s f, input int k);
      @(posedge core_clk);
      arst_n <= 1'b0;
      fuse_pin <= f;
      sel <= k;
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
   endtask

   task automatic boot(input css_fuse_s f, input int k, input logic [3:0] oh);
      int b;
      rst(f, k);
      b = edges;
      wait_en(exp_edges(f) * 8 + 200);
      chk_rng(edges - b, exp_edges(f), exp_edges(f) + 4);
      chk(src_sel_oh, oh);
      chk(clk_div8, !f.div8_n);
      chk({flash_clk_en, io_clk_en}, 2'h3);
   endtask

   task automatic boot_err(input css_fuse_s f);
      rst(f, 0);
      repeat (60) @(negedge core_clk);
      chk(cfg_error, 1'b1);
      chk(cpu_clk_en, 1'b0);
   endtask

   // -------------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------------
   task automatic t_default();
      boot(8'h49, SRC_RC, 4'h2);
      chk(rc_fast, 1'b1);
      chk(osc_trim, 8'hC3);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd, {15'h0, 1'b0, 1'b1, 1'b1, 4'h2, 6'(S_RUN), 4'h0});
      apb(1'b0, ADDR_FUSE, 32'h0);
      chk(rd, 32'h49);
   endtask

   // Every valid source code except 0100, with several start-up codes and the reset pin disabled.
   task automatic t_sources();
      boot(8'h03, SRC_EXT, 4'h1);
      boot(8'h0B, SRC_EXT, 4'h1);
      boot(8'h02, SRC_EXT, 4'h1);
      boot(8'h67, SRC_LF, 4'h4);
      boot(8'h23, SRC_RC, 4'h2);
      chk(rc_fast, 1'b0);
      for (int c = 8; c < 16; c++) begin
         boot({c[3:0], 4'h3}, SRC_XT, 4'h8);
      end
      boot(8'h97, SRC_XT, 4'h8);
   endtask

   task automatic t_reserved();
      for (int c = 1; c < 8; c += 2) begin
         boot_err({c[3:0], 4'h3});
      end
      boot_err(8'h0F);
   endtask

   task automatic t_regs();
      apb(1'b1, ADDR_CAL, 32'h5A);
      apb(1'b0, ADDR_CAL, 32'h0);
      chk(rd, 32'h5A);
      chk(osc_trim, 8'h5A);
      apb(1'b0, 8'h10, 32'h0);
      chk(se, 1'b1);
      chk(rd, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h2);
      // The write lands on the edge the task returns at, so look half a cycle later.
      @(negedge core_clk);
      chk(clk_div8, 1'b1);
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(clk_div8, 1'b0);
      chk(rd, 32'h0);
   endtask

   // Sleep through the control register, then wake on the pin with the short count.
   task automatic t_sleep();
      int b;
      apb(1'b1, ADDR_CTRL, 32'h1);
      repeat (2) @(negedge core_clk);
      chk({cpu_clk_en, flash_clk_en}, 2'h0);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd[9:4], 6'(S_SLEEP));
      @(posedge core_clk);
      wake_pin <= 1'b1;
      b = edges;
      wait_en(200);
      chk_rng(edges - b, WAKE_CK_RC, WAKE_CK_RC + 2);
      @(posedge core_clk);
      wake_pin <= 1'b0;
   endtask

   initial begin
      t_default();
      t_sources();
      t_reserved();
      boot(8'h03, SRC_EXT, 4'h1);
      t_regs();
      t_sleep();
      conclude();
   end
endmodule // testbench
